// ===== mrb_readback.sv
// Readback block: encoder, aux I/O, logical I/O and switch status reads.
`timescale 1ns/100ps
`default_nettype none
`include "mrb_consts.svh"
module mrb_readback #(
    parameter int NAXES = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output mrb_pkg::mrb_word_t avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NAXES-1:0] enc_a,
    input wire logic [NAXES-1:0] enc_b,
    input wire logic enc_fitted,
    input wire logic [7:0] aux_a_in,
    output logic [7:0] aux_b_out,
    input wire logic [7:0] aux_c_in,
    output logic [7:0] aux_c_out,
    output logic aux_c_oe_n,
    input wire logic [3:0] lio_in,
    output logic [NAXES-1:0] inhibit,
    input wire logic [NAXES-1:0] fol_err_trip,
    input wire logic [NAXES-1:0][31:0] axis_pos,
    input wire logic [NAXES-1:0] axis_vel_mode,
    input wire logic [NAXES-1:0] lim_fwd,
    input wire logic [NAXES-1:0] lim_rev,
    input wire logic [NAXES-1:0] home_sw
);
    import mrb_pkg::*;

    // =================================================================
    // Helper functions.
    function automatic logic hit(input logic [4:0] addr,
                                 input logic [4:0] off);
        hit = (addr[4:2] == off[4:2]);
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        be_merge = r;
    endfunction

    // =================================================================
    // Declarations.
    localparam int SYNC_W = 8 + 8 + 1 + 4 + 3 * NAXES;

    logic [SYNC_W-1:0] pin_meta_q;
    logic [SYNC_W-1:0] pin_sync_q;
    logic [7:0] a_s;
    logic [7:0] c_s;
    logic enc_fit_s;
    logic [3:0] lio_s;
    logic [NAXES-1:0] fwd_s;
    logic [NAXES-1:0] rev_s;
    logic [NAXES-1:0] home_s;

    logic [NAXES-1:0][31:0] enc_cnt;

    logic ack_q;
    logic ack_d;
    logic wr_take;
    mrb_word_t rdata_q;
    mrb_word_t rdata_d;

    mrb_word_t result_q;
    mrb_word_t rdb_q;
    logic pend_q;
    logic ferr_q;
    logic [15:0] aux_out_q;
    logic [23:0] aux_pol_q;
    logic [11:0] lim_pol_q;
    logic [4:0] ctrl_q;
    logic [NAXES-1:0] inh_q;

    logic cmd_go;
    mrb_op_t op;
    logic [1:0] cmd_axis;
    logic cmd_buf;
    logic [1:0] cmd_mode;
    logic is_read_op;
    logic op_err;
    mrb_word_t op_res;
    logic comm_fetch;
    logic ferr_clr;

    logic c_out_dir;
    logic [7:0] a_byte;
    logic [7:0] b_byte;
    logic [7:0] c_byte;
    mrb_word_t aux_word;
    mrb_word_t lio_word;
    logic [11:0] sw_raw;
    mrb_word_t sw_word;
    mrb_word_t enc_word;
    mrb_word_t pos_word;
    logic [NAXES-1:0] kill_set;
    logic [NAXES-1:0] inh_clr;

    // =================================================================
    // Pin synchroniser, two stages before any use.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= {aux_a_in, aux_c_in, enc_fitted, lio_in,
                           lim_fwd, lim_rev, home_sw};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign {a_s, c_s, enc_fit_s, lio_s, fwd_s, rev_s, home_s} = pin_sync_q;

    // =================================================================
    // Encoder counters, one per axis.
    for (genvar g = 0; g < NAXES; g++) begin : g_enc
        mrb_quad_cnt #(
            .CNT_W(32)
        ) u_cnt (
            .clk(clk),
            .reset_n(reset_n),
            .enc_a(enc_a[g]),
            .enc_b(enc_b[g]),
            .count(enc_cnt[g])
        );
    end

    // =================================================================
    // Avalon slave: one wait cycle, then the answer.
    assign ack_d = (avs_read || avs_write) && !ack_q;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign wr_take = avs_write && ack_q;

    always_comb begin
        rdata_d = `MRB_RST_WORD;
        if (hit(avs_address, `MRB_OFF_RESULT)) begin
            rdata_d = result_q;
        end else if (hit(avs_address, `MRB_OFF_STATUS)) begin
            rdata_d[`MRB_ST_PEND_BIT] = pend_q;
            rdata_d[`MRB_ST_FERR_BIT] = ferr_q;
            rdata_d[`MRB_ST_CDIR_BIT] = c_out_dir;
            rdata_d[`MRB_ST_ENC_BIT] = enc_fit_s;
        end else if (hit(avs_address, `MRB_OFF_RDB)) begin
            rdata_d = rdb_q;
        end else if (hit(avs_address, `MRB_OFF_AUX_OUT)) begin
            rdata_d[15:0] = aux_out_q;
        end else if (hit(avs_address, `MRB_OFF_AUX_POL)) begin
            rdata_d[23:0] = aux_pol_q;
        end else if (hit(avs_address, `MRB_OFF_LIM_POL)) begin
            rdata_d[11:0] = lim_pol_q;
        end else if (hit(avs_address, `MRB_OFF_CTRL)) begin
            rdata_d[4:0] = ctrl_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
            rdata_q <= `MRB_RST_WORD;
        end else begin
            ack_q <= ack_d;
            if (avs_read && !ack_q) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign avs_readdata = rdata_q;

    // =================================================================
    // Configuration registers.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aux_out_q <= `MRB_RST_AUX_OUT;
            aux_pol_q <= `MRB_RST_AUX_POL;
            lim_pol_q <= `MRB_RST_LIM_POL;
            ctrl_q <= `MRB_RST_CTRL;
        end else if (wr_take) begin
            if (hit(avs_address, `MRB_OFF_AUX_OUT)) begin
                aux_out_q <= 16'(be_merge({16'h0000, aux_out_q},
                                      avs_writedata, avs_byteenable));
            end
            if (hit(avs_address, `MRB_OFF_AUX_POL)) begin
                aux_pol_q <= 24'(be_merge({8'h00, aux_pol_q},
                                      avs_writedata, avs_byteenable));
            end
            if (hit(avs_address, `MRB_OFF_LIM_POL)) begin
                lim_pol_q <= 12'(be_merge({20'h0_0000, lim_pol_q},
                                      avs_writedata, avs_byteenable));
            end
            if (hit(avs_address, `MRB_OFF_CTRL) && avs_byteenable[0]) begin
                ctrl_q <= avs_writedata[4:0]; // RULE13
            end
        end
    end

    // =================================================================
    // Aux port: A inputs, B outputs, C selectable.
    assign c_out_dir = ctrl_q[`MRB_CTRL_CDIR_BIT];
    assign aux_b_out = aux_out_q[7:0] ^ aux_pol_q[15:8]; // RULE14
    assign aux_c_out = aux_out_q[15:8] ^ aux_pol_q[23:16]; // RULE14
    assign aux_c_oe_n = !c_out_dir;
    assign a_byte = a_s ^ aux_pol_q[7:0]; // RULE10 RULE14
    assign b_byte = aux_out_q[7:0]; // RULE11
    assign c_byte = c_out_dir ? aux_out_q[15:8] :
                    (c_s ^ aux_pol_q[23:16]); // RULE11 RULE14
    assign aux_word = {c_out_dir ? `MRB_DIR_OUTPUTS : `MRB_DIR_INPUTS,
                       c_byte, b_byte, a_byte}; // RULE8 RULE9 RULE12

    // =================================================================
    // Logical I/O port and switch status words.
    assign lio_word = {16'h0000, `MRB_ZERO_BYTE,
                       inh_q, lio_s}; // RULE15 RULE16
    for (genvar g = 0; g < NAXES; g++) begin : g_sw
        assign sw_raw[11-g] = home_s[g];
        assign sw_raw[7-2*g] = fwd_s[g];
        assign sw_raw[6-2*g] = rev_s[g];
    end
    assign sw_word = {16'h0000, `MRB_ZERO_NIB,
                      sw_raw ^ lim_pol_q}; // RULE18 RULE19

    // =================================================================
    // Encoder and position selection for the addressed axis.
    assign enc_word = enc_cnt[cmd_axis]; // RULE1 RULE4 RULE5
    assign pos_word = axis_vel_mode[cmd_axis] ? `MRB_RST_WORD :
                      axis_pos[cmd_axis]; // RULE7

    // =================================================================
    // Command decode.
    assign cmd_go = wr_take && hit(avs_address, `MRB_OFF_CMD);
    assign op = mrb_op_t'(avs_writedata[`MRB_CMD_OP_LSB +: 4]);
    assign cmd_axis = avs_writedata[`MRB_CMD_AXIS_LSB +: 2];
    assign cmd_buf = avs_writedata[`MRB_CMD_BUF_BIT];
    assign cmd_mode = avs_writedata[`MRB_CMD_MODE_LSB +: 2];
    assign ferr_clr = wr_take && hit(avs_address, `MRB_OFF_STATUS) &&
                      avs_byteenable[0] &&
                      avs_writedata[`MRB_ST_FERR_BIT];

    always_comb begin
        op_res = `MRB_RST_WORD;
        is_read_op = 1'b0;
        op_err = 1'b0;
        unique case (op)
            MRB_OP_READ_ENC: begin
                is_read_op = enc_fit_s; // RULE3
                op_err = !enc_fit_s; // RULE2
                op_res = enc_word;
            end
            MRB_OP_READ_AUX: begin
                is_read_op = 1'b1;
                op_res = aux_word;
            end
            MRB_OP_READ_LIO: begin
                is_read_op = 1'b1;
                op_res = lio_word;
            end
            MRB_OP_READ_SW: begin
                is_read_op = 1'b1;
                op_res = sw_word;
            end
            MRB_OP_READ_POS: begin
                is_read_op = 1'b1;
                op_res = pos_word;
            end
            MRB_OP_NOP, MRB_OP_KILL, MRB_OP_COMM, MRB_OP_CLR_INH: begin
                is_read_op = 1'b0;
            end
            default: begin
                op_err = 1'b1;
            end
        endcase
    end

    assign comm_fetch = cmd_go && (op == MRB_OP_COMM) &&
                        (cmd_mode == `MRB_RDB_MODE) && pend_q; // RULE6

    // =================================================================
    // Results, return slot and error flag.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            result_q <= `MRB_RST_WORD;
            rdb_q <= `MRB_RST_WORD;
            pend_q <= 1'b0;
            ferr_q <= 1'b0;
        end else begin
            if (cmd_go && is_read_op && cmd_buf) begin
                rdb_q <= op_res; // RULE6
            end
            if (cmd_go && is_read_op && !cmd_buf) begin
                result_q <= op_res; // RULE4
            end else if (comm_fetch) begin
                result_q <= rdb_q; // RULE6
            end
            if (cmd_go && is_read_op && cmd_buf) begin
                pend_q <= 1'b1;
            end else if (comm_fetch) begin
                pend_q <= 1'b0;
            end
            if (cmd_go && op_err) begin
                ferr_q <= 1'b1; // RULE2
            end else if (ferr_clr) begin
                ferr_q <= 1'b0;
            end
        end
    end

    // =================================================================
    // Inhibit lines: kill or closed-loop following trip sets them.
    for (genvar g = 0; g < NAXES; g++) begin : g_inh
        assign kill_set[g] = cmd_go && (op == MRB_OP_KILL) &&
                             (cmd_axis == 2'(g));
        assign inh_clr[g] = cmd_go && (op == MRB_OP_CLR_INH) &&
                            (cmd_axis == 2'(g));
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            inh_q <= '0;
        end else begin
            inh_q <= (inh_q & ~inh_clr) | kill_set |
                     (fol_err_trip & ctrl_q[NAXES-1:0]); // RULE17
        end
    end

    assign inhibit = inh_q;
endmodule
`default_nettype wire

// ===== mrb_consts.svh
// Register offsets, field positions, reset values and codes of the readback block.
//
// How it works
// RULE1: Encoder read returns full signed 32-bit count.
// RULE2: Encoder read without encoder fitted raises error.
// RULE3: Encoder reads work regardless of loop setting.
// RULE4: Encoder read captures live count at execution.
// RULE5: Encoder counts are raw, never scaled or offset.
// RULE6: Buffered reads fill return slot; mode 2 fetches.
// RULE7: Position read gives zero in velocity mode.
// RULE8: Aux word bits 23..16 hold selectable port.
// RULE9: Aux top byte: FF inputs, 00 outputs.
// RULE10: Aux data bit one means high line.
// RULE11: Aux shows programmed outputs; selectable only if output.
// RULE12: Aux port: input, output, selectable byte groups.
// RULE13: Host sets selectable direction matching hardware switch.
// RULE14: Programmed aux polarity applies to readback values.
// RULE15: Logical port read: upper byte zero, lower logical.
// RULE16: Logical port bits 7..4 show inhibit lines.
// RULE17: Inhibit set on kill or closed-loop following trip.
// RULE18: Switch word: zeros, homes, limit pairs axis-first.
// RULE19: Limit values reported after per-input inversion.
`ifndef MRB_CONSTS_SVH
`define MRB_CONSTS_SVH

// =====================================================================
// Register byte offsets
`define MRB_OFF_CMD 5'h00
`define MRB_OFF_RESULT 5'h04
`define MRB_OFF_STATUS 5'h08
`define MRB_OFF_RDB 5'h0C
`define MRB_OFF_AUX_OUT 5'h10
`define MRB_OFF_AUX_POL 5'h14
`define MRB_OFF_LIM_POL 5'h18
`define MRB_OFF_CTRL 5'h1C

// =====================================================================
// Field positions
`define MRB_CMD_OP_LSB 0
`define MRB_CMD_AXIS_LSB 4
`define MRB_CMD_BUF_BIT 8
`define MRB_CMD_MODE_LSB 10
`define MRB_ST_PEND_BIT 0
`define MRB_ST_FERR_BIT 1
`define MRB_ST_CDIR_BIT 2
`define MRB_ST_ENC_BIT 3
`define MRB_CTRL_CDIR_BIT 4

// =====================================================================
// Reset values and codes
`define MRB_RST_WORD 32'h0000_0000
`define MRB_RST_AUX_OUT 16'h0000
`define MRB_RST_AUX_POL 24'h00_0000
`define MRB_RST_LIM_POL 12'h000
`define MRB_RST_CTRL 5'h00
`define MRB_RDB_MODE 2'h2
`define MRB_DIR_INPUTS 8'hFF
`define MRB_DIR_OUTPUTS 8'h00
`define MRB_ZERO_BYTE 8'h00
`define MRB_ZERO_NIB 4'h0

`endif

// ===== mrb_pkg.sv
// Types shared by the readback block.
`default_nettype none
package mrb_pkg;

    // =================================================================
    // Command codes
    typedef enum logic [3:0] {
        MRB_OP_NOP = 4'h0,
        MRB_OP_READ_ENC = 4'h1,
        MRB_OP_READ_AUX = 4'h2,
        MRB_OP_READ_LIO = 4'h3,
        MRB_OP_READ_SW = 4'h4,
        MRB_OP_READ_POS = 4'h5,
        MRB_OP_KILL = 4'h6,
        MRB_OP_COMM = 4'h7,
        MRB_OP_CLR_INH = 4'h8
    } mrb_op_t;

    typedef logic [31:0] mrb_word_t;

endpackage
`default_nettype wire

// ===== mrb_quad_cnt.sv
// Quadrature decoder and raw 32-bit encoder counter for one axis.
`timescale 1ns/100ps
`default_nettype none
module mrb_quad_cnt #(
    parameter int CNT_W = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enc_a,
    input wire logic enc_b,
    output logic [CNT_W-1:0] count
);
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] prev_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic step_up;
    logic step_dn;

    // =================================================================
    // Pin synchroniser.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_q <= 2'h0;
            sync_q <= 2'h0;
            prev_q <= 2'h0;
        end else begin
            meta_q <= {enc_a, enc_b};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // =================================================================
    // Four counts per line cycle, no scaling of any kind.
    assign step_up = (prev_q == 2'h0 && sync_q == 2'h2) ||
                     (prev_q == 2'h2 && sync_q == 2'h3) ||
                     (prev_q == 2'h3 && sync_q == 2'h1) ||
                     (prev_q == 2'h1 && sync_q == 2'h0); // RULE5
    assign step_dn = (prev_q == 2'h0 && sync_q == 2'h1) ||
                     (prev_q == 2'h1 && sync_q == 2'h3) ||
                     (prev_q == 2'h3 && sync_q == 2'h2) ||
                     (prev_q == 2'h2 && sync_q == 2'h0); // RULE5
    assign cnt_d = step_up ? cnt_q + CNT_W'(1) :
                   step_dn ? cnt_q - CNT_W'(1) : cnt_q; // RULE1

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;
endmodule
`default_nettype wire

// ===== mrb_readback_monitor.sv
// Checker of bus timing and output behaviour of the readback block.
`timescale 1ns/100ps
`default_nettype none
module mrb_readback_chk #(
    parameter int NAXES = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire mrb_pkg::mrb_word_t avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic aux_c_oe_n,
    input wire logic [NAXES-1:0] inhibit,
    input wire logic [NAXES-1:0] fol_err_trip
);
    import mrb_pkg::*;
    // ========
    // Mirrors of the last command's code, zero if it was buffered or after a control write, and of the control register.
    logic [3:0] op_q;
    logic [4:0] ctrl_q;
    wire logic req = avs_read || avs_write;
    wire logic acc = avs_write && !avs_waitrequest;
    wire logic rok = avs_read && !avs_waitrequest;
    wire logic [2:0] wa = avs_address[4:2];
    wire logic [3:0] wop = avs_writedata[3:0];
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            op_q <= 4'h0;
            ctrl_q <= 5'h00;
        end else if (acc && wa == 3'h0) begin
            op_q <= avs_writedata[8] ? 4'h0 : wop;
        end else if (acc && wa == 3'h7 && avs_byteenable[0]) begin
            op_q <= 4'h0;
            ctrl_q <= avs_writedata[4:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ========
    // Properties.
    property p_wait_new;
        req && !$past(req) |-> avs_waitrequest;
    endproperty
    a_wait_new: assert property (p_wait_new) else $error("No wait state.");
    property p_wait_one;
        avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("Wait too long.");
    property p_rd_hold;
        !avs_read |=> $stable(avs_readdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("Read data moved.");
    property p_cmd_zero;
        rok && wa == 3'h0 |-> avs_readdata == 32'h0000_0000;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("Command read.");
    property p_oe;
        aux_c_oe_n == !ctrl_q[4];
    endproperty
    a_oe: assert property (p_oe) else $error("Port C enable.");
    property p_kill;
        acc && wa == 3'h0 && wop == 4'h6
            |-> ##2 inhibit[$past(avs_writedata[5:4], 2)];
    endproperty
    a_kill: assert property (p_kill) else $error("Kill lost.");
    property p_trip;
        fol_err_trip[0] && ctrl_q[0] |=> inhibit[0];
    endproperty
    a_trip: assert property (p_trip) else $error("Trip lost.");
    property p_sw_top;
        rok && wa == 3'h1 && op_q == 4'h4 |-> avs_readdata[31:12] == 20'h0;
    endproperty
    a_sw_top: assert property (p_sw_top) else $error("Switch top.");
    property p_lio_top;
        rok && wa == 3'h1 && op_q == 4'h3 |-> avs_readdata[31:8] == 24'h0;
    endproperty
    a_lio_top: assert property (p_lio_top) else $error("Port top.");
    property p_aux_dir;
        rok && wa == 3'h1 && op_q == 4'h2
            |-> avs_readdata[31:24] == (ctrl_q[4] ? 8'h00 : 8'hFF);
    endproperty
    a_aux_dir: assert property (p_aux_dir) else $error("Aux dir.");
    c_kill: cover property (acc && wa == 3'h0 && wop == 4'h6);
    c_trip: cover property (fol_err_trip[0] && ctrl_q[0]);
    c_buf: cover property (acc && wa == 3'h0 && avs_writedata[8]);
endmodule
bind mrb_readback mrb_readback_chk #(.NAXES(NAXES)) chk_u (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .aux_c_oe_n(aux_c_oe_n), .inhibit(inhibit),
    .fol_err_trip(fol_err_trip)
);
`default_nettype wire

// ===== mrb_host_bfm.sv
// Host model that reaches the readback block over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module mrb_host_bfm (
    input wire logic clk,
    output logic [4:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    output logic hung
);
    logic wait_q;
    initial begin
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        hung = 1'b0;
    end
    // ========
    // Waitrequest as it stands over the cycle before each rising edge.
    always @(negedge clk) begin
        wait_q <= avs_waitrequest;
    end
    task automatic xfer(input logic rd, input logic [4:0] a,
                        input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_q !== 1'b0 && n < 20);
        hung <= (n >= 20);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= ~d;
    endtask
    // Fetch from the return slot with the given communicate mode.
    task automatic fetch(input logic [1:0] m);
        xfer(1'b0, 5'h00, {20'h0, m, 10'h007});
    endtask
endmodule
`default_nettype wire

// ===== mrb_readback_tb_top.sv
// Self-checking bench of the readback block.
`timescale 1ns/100ps
`default_nettype none
module mrb_readback_tb_top;
    import mrb_pkg::*;
    logic clk, reset_n, enc_fitted, aux_c_oe_n, hung;
    logic avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, p, o, e;
    logic [3:0] avs_byteenable, enc_a, enc_b, lio_in, inhibit, l;
    logic [3:0] fol_err_trip, axis_vel_mode, lim_fwd, lim_rev, home_sw;
    logic [3:0] f, r, h, vm;
    logic [7:0] aux_a_in, aux_b_out, aux_c_in, aux_c_out, a, c;
    logic [1:0] ax, k;
    logic [11:0] lp;
    logic [3:0][31:0] axis_pos, pv;
    mrb_word_t avs_readdata;
    mrb_word_t exp_q[$];
    int fail_count, n_compared, n;
    int ph [4];
    mrb_host_bfm host_u (
        .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_waitrequest(avs_waitrequest), .hung(hung)
    );
    mrb_readback #(.NAXES(4)) dut_u (
        .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .enc_a(enc_a), .enc_b(enc_b), .enc_fitted(enc_fitted),
        .aux_a_in(aux_a_in), .aux_b_out(aux_b_out), .aux_c_in(aux_c_in),
        .aux_c_out(aux_c_out), .aux_c_oe_n(aux_c_oe_n), .lio_in(lio_in),
        .inhibit(inhibit), .fol_err_trip(fol_err_trip),
        .axis_pos(axis_pos), .axis_vel_mode(axis_vel_mode),
        .lim_fwd(lim_fwd), .lim_rev(lim_rev), .home_sw(home_sw)
    );
    // ========
    // Shared tasks.
    task automatic print_verdict;
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic rd(input logic [4:0] ad, input logic [31:0] x);
        exp_q.push_back(x);
        host_u.xfer(1'b1, ad, 32'h0000_0000);
    endtask
    task automatic wr(input logic [4:0] ad, input logic [31:0] d);
        host_u.xfer(1'b0, ad, d);
    endtask
    task automatic cmd(input logic [3:0] op, input logic [1:0] x,
                       input logic [31:0] v);
        wr(5'h00, {26'h0, x, op});
        rd(5'h04, v);
    endtask
    // Quarter steps on one axis, forward for positive counts.
    task automatic step(input logic [1:0] x, input int cnt);
        for (int i = 0; i < (cnt < 0 ? -cnt : cnt); i++) begin
            @(posedge clk);
            ph[x] = (ph[x] + (cnt < 0 ? 3 : 1)) % 4;
            enc_a[x] <= (ph[x] == 1 || ph[x] == 2);
            enc_b[x] <= (ph[x] >= 2);
        end
        repeat (5) @(posedge clk);
    endtask
    always #50 clk = ~clk;
    always @(negedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            chk(avs_readdata, exp_q.pop_front());
        end
    end
    always @(posedge clk) begin
        if (hung === 1'b1) begin
            fail_count++;
            print_verdict();
        end
    end
    // ========
    // Main sequence.
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {enc_a, enc_b, lio_in, fol_err_trip, axis_vel_mode} = 20'h0;
        {lim_fwd, lim_rev, home_sw, aux_a_in, aux_c_in} = 28'h0;
        axis_pos = '0;
        enc_fitted = 1'b1;
        void'($urandom(18));
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk({19'h0, aux_c_oe_n, inhibit, aux_b_out}, 32'h0000_1000);
        rd(5'h08, 32'h0000_0008);
        rd(5'h00, 32'h0000_0000);
        ax = 2'($urandom_range(3, 0));
        n = $urandom_range(40, 5);
        step(ax, n);
        cmd(4'h1, ax, 32'(n));
        step(ax, -n - 3);
        cmd(4'h1, ax, 32'hFFFF_FFFD);
        step(ax, 2);
        wr(5'h00, {23'h0, 1'b1, 2'h0, ax, 4'h1});
        rd(5'h08, 32'h0000_0009);
        rd(5'h0C, 32'hFFFF_FFFF);
        for (int m = 0; m < 4; m++) begin
            host_u.fetch(2'(3 - m));
            rd(5'h04, m == 0 ? 32'hFFFF_FFFD : 32'hFFFF_FFFF);
            rd(5'h08, m == 0 ? 32'h9 : 32'h8);
        end
        p = $urandom;
        o = $urandom;
        wr(5'h14, p);
        wr(5'h10, o);
        for (int d = 0; d < 2; d++) begin
            a = 8'($urandom);
            c = 8'($urandom);
            aux_a_in <= a;
            aux_c_in <= c;
            wr(5'h1C, 32'(d) << 4);
            rd(5'h08, 32'h8 | (32'(d) << 2));
            e = d ? {8'h00, o[15:0], a ^ p[7:0]} :
                {8'hFF, c ^ p[23:16], o[7:0], a ^ p[7:0]};
            cmd(4'h2, 2'h0, e);
            chk({15'h0, aux_c_oe_n, aux_c_out, aux_b_out},
                {15'h0, d == 0, o[15:8] ^ p[23:16], o[7:0] ^ p[15:8]});
        end
        {f, r, h, lp} = 24'($urandom);
        lim_fwd <= f;
        lim_rev <= r;
        home_sw <= h;
        wr(5'h18, {20'h0, lp});
        e = {20'h0, lp};
        for (int i = 0; i < 4; i++) begin
            e[11 - i] ^= h[i];
            e[7 - 2 * i] ^= f[i];
            e[6 - 2 * i] ^= r[i];
        end
        cmd(4'h4, 2'h0, e);
        l = 4'($urandom);
        lio_in <= l;
        k = 2'($urandom_range(3, 0));
        wr(5'h00, {26'h0, k, 4'h6});
        repeat (2) @(posedge clk);
        chk({28'h0, inhibit}, 32'h1 << k);
        cmd(4'h3, 2'h0, {24'h0, 4'h1 << k, l});
        wr(5'h00, {26'h0, k, 4'h8});
        wr(5'h1C, 32'h0000_0001);
        fol_err_trip <= 4'h3;
        @(posedge clk);
        fol_err_trip <= 4'h0;
        repeat (2) @(posedge clk);
        chk({28'h0, inhibit}, 32'h0000_0001);
        pv = {$urandom, $urandom, $urandom, $urandom};
        vm = 4'($urandom);
        axis_pos <= pv;
        axis_vel_mode <= vm;
        for (int i = 0; i < 4; i++) begin
            cmd(4'h5, 2'(i), vm[i] ? 32'h0 : pv[i]);
        end
        enc_fitted <= 1'b0;
        wr(5'h00, 32'h0000_0001);
        rd(5'h08, 32'h0000_0002);
        for (int i = 9; i < 16; i++) begin
            wr(5'h08, 32'h0000_0002);
            wr(5'h00, 32'(i));
            rd(5'h08, 32'h0000_0002);
        end
        wr(5'h08, 32'h0000_0002);
        rd(5'h08, 32'h0000_0000);
        print_verdict();
    end
endmodule
`default_nettype wire
